// [core/lpt_map.svh]
// Purpose: offsets, reset values and counts of the link test unit
// Assumes: 16-bit command addresses, 16-bit data
// Notes: definitions only
`ifndef LPT_MAP_SVH
`define LPT_MAP_SVH
// ----------------------------------------
// Command offsets
// ----------------------------------------
`define LPT_RO_START 16'h9000
`define LPT_RO_ERR 16'h900C
`define LPT_PC_START 16'h9100
`define LPT_PC_ERR 16'h910C
`define LPT_FE_START 16'h9200
`define LPT_FE_SEL 16'h9204
`define LPT_FE_EDGE 16'h9208
`define LPT_FE_ERR 16'h920C
`define LPT_FE_TYPE 16'h9300
`define LPT_TMB_START 16'h9400
`define LPT_TMB_EN 16'h9404
`define LPT_TMB_GOOD 16'h9408
`define LPT_TMB_ERR 16'h940C
`define LPT_TMB_CLR 16'h9410
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define LPT_SEL_RST 16'h0000
`define LPT_TYPE_RST 16'h0001
`define LPT_GEN_SEED 7'h7F
`define LPT_SEQ_BITS 14'h007F
`define LPT_BLK_BITS 14'h2710
`define LPT_FIBERS 7
`endif

// [core/lpt_pkg.sv]
// Purpose: types of the link test unit
// Assumes: one clock domain
// Notes: all state lives in lpt_state_s
package lpt_pkg;
  typedef enum logic [1:0] {PH_IDLE, PH_SEED, PH_RUN} lpt_phase_e;
  typedef enum logic [1:0] {POLY_7, POLY_15, POLY_23, POLY_31} lpt_poly_e;
  typedef struct packed {
    logic strobe;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } lpt_cmd_s;
  typedef struct packed {
    logic valid;
    logic data;
  } lpt_bit_s;
  typedef struct packed {
    lpt_phase_e phase;
    logic [30:0] hist;
    logic [4:0] seed;
    logic [13:0] bits;
    logic [15:0] blks;
    logic [15:0] target;
    logic bad;
    logic err;
    logic good;
  } lpt_chk_s;
  typedef struct packed {
    logic run;
    logic [6:0] lfsr;
    logic [13:0] bits;
    logic [15:0] blks;
    logic [15:0] target;
  } lpt_gen_s;
  typedef struct packed {
    lpt_gen_s ro_gen;
    lpt_gen_s pc_gen;
    lpt_chk_s ro_chk;
    lpt_chk_s pc_chk;
    lpt_chk_s fe_chk;
    lpt_chk_s tmb_chk;
    logic [15:0] ro_err;
    logic [15:0] pc_err;
    logic [15:0] fe_edge;
    logic [15:0] fe_err;
    logic [15:0] fe_sel;
    logic [15:0] fe_type;
    logic [15:0] tmb_en;
    logic [15:0] tmb_good;
    logic [15:0] tmb_err;
    logic fe_prev;
    lpt_bit_s ro_tx;
    lpt_bit_s pc_tx;
    logic ack;
    logic [15:0] rdata;
  } lpt_state_s;
endpackage

// [core/lpt_unit.sv]
// Purpose: PRBS self-test of readout, PC, front-end and trigger links
// Assumes: link bit streams arrive on the system clock
// Notes: checkers are self-synchronising, so link latency is free
//
// Notes on behaviour
// - readout start runs N PRBS-7 sequences loopback
// - readout error count readable after test
// - PC start runs N PRBS-7 sequences loopback
// - PC error count readable after test
// - front-end start checks N times 10000 bits
// - front-end fiber selector readable and writable
// - count error edges during front-end check
// - count front-end bit mismatches
// - pattern type 1..4 selects PRBS-7/15/23/31
// - trigger start checks N times 10000 bits
// - count trigger enables during check
// - count error-free trigger 10000-bit blocks
// - count trigger bit mismatches
// - trigger error reset clears mismatch count
`include "lpt_map.svh"

module lpt_unit
  import lpt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire lpt_cmd_s cmd,
  output logic cmd_ack,
  output logic [15:0] cmd_rdata,
  output lpt_bit_s ro_tx,
  input wire lpt_bit_s ro_rx,
  output lpt_bit_s pc_tx,
  input wire lpt_bit_s pc_rx,
  input wire lpt_bit_s [`LPT_FIBERS-1:0] fe_rx,
  input wire lpt_bit_s tmb_rx,
  input wire logic tmb_enable
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Saturate so a long test never wraps to a small count
  function automatic logic [15:0] sat_inc(
    input logic [15:0] v,
    input logic en
  );
    sat_inc = (en && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction

  // Pattern type code to polynomial; unknown codes fall to PRBS-7
  function automatic lpt_poly_e poly_of(input logic [15:0] v);
    case (v)
      16'h0002: poly_of = POLY_15;
      16'h0003: poly_of = POLY_23;
      16'h0004: poly_of = POLY_31;
      default: poly_of = POLY_7;
    endcase
  endfunction

  // Bits of history needed before prediction works, minus one
  function automatic logic [4:0] seed_last(input lpt_poly_e p);
    case (p)
      POLY_15: seed_last = 5'h0E;
      POLY_23: seed_last = 5'h16;
      POLY_31: seed_last = 5'h1E;
      default: seed_last = 5'h06;
    endcase
  endfunction

  // Expected next bit from history, newest bit in hist[0]
  function automatic logic predict(
    input logic [30:0] h,
    input lpt_poly_e p
  );
    case (p)
      POLY_15: predict = h[14] ^ h[13];
      POLY_23: predict = h[22] ^ h[17];
      POLY_31: predict = h[30] ^ h[27];
      default: predict = h[6] ^ h[5];
    endcase
  endfunction

  // Arm a checker; a zero count leaves it idle
  function automatic lpt_chk_s chk_start(
    input lpt_chk_s c,
    input logic [15:0] n
  );
    lpt_chk_s r;
    r = c;
    r.phase = (n == 16'h0000) ? PH_IDLE : PH_SEED;
    r.seed = 5'h00;
    r.bits = 14'h0000;
    r.blks = 16'h0000;
    r.target = n;
    r.bad = 1'b0;
    r.err = 1'b0;
    r.good = 1'b0;
    chk_start = r;
  endfunction

  // One received bit through a checker; err and good are pulses
  function automatic lpt_chk_s chk_step(
    input lpt_chk_s c,
    input lpt_bit_s b,
    input lpt_poly_e p,
    input logic [13:0] len
  );
    lpt_chk_s r;
    logic miss;
    r = c;
    r.err = 1'b0;
    r.good = 1'b0;
    miss = (b.data != predict(c.hist, p));
    if (b.valid) begin
      r.hist = {c.hist[29:0], b.data};
      case (c.phase)
        PH_SEED: begin
          r.seed = c.seed + 5'h01;
          if (c.seed == seed_last(p)) begin
            r.phase = PH_RUN;
          end
        end
        PH_RUN: begin
          r.err = miss;
          r.bad = c.bad | miss;
          r.bits = c.bits + 14'h0001;
          if (c.bits == len - 14'h0001) begin
            r.bits = 14'h0000;
            r.blks = c.blks + 16'h0001;
            r.good = ~(c.bad | miss);
            r.bad = 1'b0;
            if (c.blks + 16'h0001 == c.target) begin
              r.phase = PH_IDLE;
            end
          end
        end
        default: r.phase = PH_IDLE;
      endcase
    end
    chk_step = r;
  endfunction

  // Loopback transmitter, PRBS-7, one bit per clock while running
  function automatic lpt_gen_s gen_step(input lpt_gen_s g);
    lpt_gen_s r;
    logic nb;
    r = g;
    nb = g.lfsr[6] ^ g.lfsr[5];
    if (g.run) begin
      r.lfsr = {g.lfsr[5:0], nb};
      r.bits = g.bits + 14'h0001;
      if (g.bits == `LPT_SEQ_BITS - 14'h0001) begin
        r.bits = 14'h0000;
        r.blks = g.blks + 16'h0001;
        if (g.blks + 16'h0001 == g.target) begin
          r.run = 1'b0;
        end
      end
    end
    gen_step = r;
  endfunction

  function automatic lpt_gen_s gen_start(input logic [15:0] n);
    lpt_gen_s r;
    r.run = (n != 16'h0000);
    r.lfsr = `LPT_GEN_SEED;
    r.bits = 14'h0000;
    r.blks = 16'h0000;
    r.target = n;
    gen_start = r;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  lpt_state_s st_r;
  lpt_state_s st_nxt;
  lpt_bit_s fe_pick;
  lpt_poly_e fe_poly;
  logic wr;
  logic fe_edge_now;

  // Fiber mux; an out-of-range select sees no data
  always_comb begin
    fe_pick = '0;
    if (st_r.fe_sel < 16'(`LPT_FIBERS)) begin
      fe_pick = fe_rx[st_r.fe_sel[2:0]];
    end
  end

  assign fe_poly = poly_of(st_r.fe_type);
  assign wr = cmd.strobe & cmd.write;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    fe_edge_now = 1'b0;

    // Generators step while running; checkers step on each valid received bit
    st_nxt.ro_gen = gen_step(st_r.ro_gen);
    st_nxt.pc_gen = gen_step(st_r.pc_gen);
    st_nxt.ro_tx.valid = st_r.ro_gen.run;
    st_nxt.ro_tx.data = st_r.ro_gen.lfsr[6] ^ st_r.ro_gen.lfsr[5];
    st_nxt.pc_tx.valid = st_r.pc_gen.run;
    st_nxt.pc_tx.data = st_r.pc_gen.lfsr[6] ^ st_r.pc_gen.lfsr[5];
    st_nxt.ro_chk = chk_step(st_r.ro_chk, ro_rx, POLY_7,
                             `LPT_SEQ_BITS);
    st_nxt.pc_chk = chk_step(st_r.pc_chk, pc_rx, POLY_7,
                             `LPT_SEQ_BITS);
    st_nxt.fe_chk = chk_step(st_r.fe_chk, fe_pick, fe_poly,
                             `LPT_BLK_BITS);
    st_nxt.tmb_chk = chk_step(st_r.tmb_chk, tmb_rx, POLY_7,
                              `LPT_BLK_BITS);

    // Result counters; they only move while a test runs
    st_nxt.ro_err = sat_inc(st_r.ro_err, st_nxt.ro_chk.err);
    st_nxt.pc_err = sat_inc(st_r.pc_err, st_nxt.pc_chk.err);
    st_nxt.fe_err = sat_inc(st_r.fe_err, st_nxt.fe_chk.err);
    if (fe_pick.valid && st_r.fe_chk.phase == PH_RUN) begin
      fe_edge_now = st_nxt.fe_chk.err & ~st_r.fe_prev;
      st_nxt.fe_prev = st_nxt.fe_chk.err;
    end
    st_nxt.fe_edge = sat_inc(st_r.fe_edge, fe_edge_now);
    st_nxt.tmb_err = sat_inc(st_r.tmb_err,
                             st_nxt.tmb_chk.err);
    st_nxt.tmb_good = sat_inc(st_r.tmb_good,
                              st_nxt.tmb_chk.good);
    st_nxt.tmb_en = sat_inc(st_r.tmb_en, tmb_enable &&
                            st_r.tmb_chk.phase != PH_IDLE);

    // Commands; a start overrides the counting above
    if (wr) begin
      case (cmd.addr)
        `LPT_RO_START: begin
          st_nxt.ro_gen = gen_start(cmd.wdata);
          st_nxt.ro_chk = chk_start(st_r.ro_chk, cmd.wdata);
          st_nxt.ro_err = 16'h0000;
        end
        `LPT_PC_START: begin
          st_nxt.pc_gen = gen_start(cmd.wdata);
          st_nxt.pc_chk = chk_start(st_r.pc_chk, cmd.wdata);
          st_nxt.pc_err = 16'h0000;
        end
        `LPT_FE_START: begin
          st_nxt.fe_chk = chk_start(st_r.fe_chk, cmd.wdata);
          st_nxt.fe_err = 16'h0000;
          st_nxt.fe_edge = 16'h0000;
          st_nxt.fe_prev = 1'b0;
        end
        `LPT_FE_SEL: st_nxt.fe_sel = cmd.wdata;
        `LPT_FE_TYPE: st_nxt.fe_type = cmd.wdata;
        `LPT_TMB_START: begin
          st_nxt.tmb_chk = chk_start(st_r.tmb_chk,
                                     cmd.wdata);
          st_nxt.tmb_err = 16'h0000;
          st_nxt.tmb_good = 16'h0000;
          st_nxt.tmb_en = 16'h0000;
        end
        `LPT_TMB_CLR: begin
          // A mismatch in the clear cycle still counts
          st_nxt.tmb_err = {15'h0000, st_nxt.tmb_chk.err};
        end
        default: st_nxt.tmb_err = st_nxt.tmb_err;
      endcase
    end

    // Read answer one clock after the strobe; others read zero
    st_nxt.ack = cmd.strobe;
    st_nxt.rdata = 16'h0000;
    if (cmd.strobe && !cmd.write) begin
      case (cmd.addr)
        `LPT_RO_ERR: st_nxt.rdata = st_r.ro_err;
        `LPT_PC_ERR: st_nxt.rdata = st_r.pc_err;
        `LPT_FE_SEL: st_nxt.rdata = st_r.fe_sel;
        `LPT_FE_EDGE: st_nxt.rdata = st_r.fe_edge;
        `LPT_FE_ERR: st_nxt.rdata = st_r.fe_err;
        `LPT_FE_TYPE: st_nxt.rdata = st_r.fe_type;
        `LPT_TMB_EN: st_nxt.rdata = st_r.tmb_en;
        `LPT_TMB_GOOD: st_nxt.rdata = st_r.tmb_good;
        `LPT_TMB_ERR: st_nxt.rdata = st_r.tmb_err;
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------

  // Counters hold between tests since only a start clears them (tmb_err also by the trigger error reset)
  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r <= '0;
      st_r.fe_sel <= `LPT_SEL_RST;
      st_r.fe_type <= `LPT_TYPE_RST;
      st_r.ro_gen.lfsr <= `LPT_GEN_SEED;
      st_r.pc_gen.lfsr <= `LPT_GEN_SEED;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmd_ack = st_r.ack;
  assign cmd_rdata = st_r.rdata;
  assign ro_tx = st_r.ro_tx;
  assign pc_tx = st_r.pc_tx;

endmodule

// [tb/link_prbs_test_unit_test.sv]
// Purpose: self-checking bench of the link test unit
// Assumes: one bit flip gives 3 mismatches in a self-syncing checker
// Notes: inputs change on the falling edge
`include "lpt_map.svh"

module link_prbs_test_unit_test
  import lpt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, resetn, bad, tmb_enable, cmd_ack;
  lpt_cmd_s cmd;
  logic [15:0] cmd_rdata;
  lpt_bit_s ro_tx, ro_rx, pc_tx, pc_rx, tmb_rx;
  lpt_bit_s [`LPT_FIBERS-1:0] fe_rx;
  int miscompares = 0, checks_done = 0, cycles = 0;

  lpt_unit dut (.clock(clock), .resetn(resetn), .cmd(cmd), .cmd_ack(cmd_ack),
    .cmd_rdata(cmd_rdata), .ro_tx(ro_tx), .ro_rx(ro_rx), .pc_tx(pc_tx),
    .pc_rx(pc_rx), .fe_rx(fe_rx), .tmb_rx(tmb_rx), .tmb_enable(tmb_enable));
  lpt_far_end far (.clock(clock), .resetn(resetn), .bad(bad), .ro_tx(ro_tx),
    .pc_tx(pc_tx), .ro_rx(ro_rx), .pc_rx(pc_rx), .fe_rx(fe_rx),
    .tmb_rx(tmb_rx));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Whole run needs about 31k cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  // One command; answer sampled half a cycle after the strobe is taken
  task automatic access(input logic w, input logic [15:0] a, d);
    @(negedge clock);
    cmd = '{1'b1, w, a, d};
    @(negedge clock);
    cmd.strobe = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    access(1'b0, a, 16'h0000);
    check(cmd_ack === 1'b1 ? cmd_rdata : 16'hDEAD, exp);
  endtask
  task automatic pulse_bad();
    @(negedge clock);
    bad = 1'b1;
    @(negedge clock);
    bad = 1'b0;
  endtask
  task automatic wait_tx(input logic pc, input logic lvl);
    for (int i = 0; i < 600 && (pc ? pc_tx.valid : ro_tx.valid) !== lvl;
         i++) @(negedge clock);
  endtask
  task automatic link_run(input logic pc, input logic [15:0] n,
                          input logic flip, input logic [15:0] exp);
    access(1'b1, pc ? 16'h9100 : 16'h9000, n);
    wait_tx(pc, 1'b1);
    repeat (60) @(negedge clock);
    if (flip) pulse_bad();
    wait_tx(pc, 1'b0);
    repeat (5) @(negedge clock);
    rd(pc ? 16'h910C : 16'h900C, exp);
  endtask

  initial begin
    resetn = 1'b0;
    bad = 1'b0;
    tmb_enable = 1'b0;
    cmd = '0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    rd(16'h9204, 16'h0000);
    rd(16'h900C, 16'h0000);
    rd(16'h9000, 16'h0000);
    rd(16'h9500, 16'h0000);
    access(1'b1, 16'h9204, 16'h0005);
    rd(16'h9204, 16'h0005);
    // Dark fiber selected: a flip on fiber 0 must not be seen
    access(1'b1, 16'h9204, 16'h0001);
    access(1'b1, 16'h9200, 16'h0001);
    repeat (100) @(negedge clock);
    pulse_bad();
    repeat (20) @(negedge clock);
    rd(16'h920C, 16'h0000);
    rd(16'h9208, 16'h0000);
    access(1'b1, 16'h9204, 16'h0000);
    for (int k = 4; k >= 1; k--) begin
      access(1'b1, 16'h9300, 16'(k));
      rd(16'h9300, 16'(k));
    end
    link_run(1'b0, 16'h0002, 1'b1, 16'h0003);
    link_run(1'b0, 16'h0001, 1'b0, 16'h0000);
    link_run(1'b1, 16'h0001, 1'b1, 16'h0003);
    access(1'b1, 16'h9200, 16'h0001);
    repeat (100) @(negedge clock);
    pulse_bad();
    repeat (10000) @(negedge clock);
    rd(16'h920C, 16'h0003);
    rd(16'h9208, 16'h0002);
    access(1'b1, 16'h9400, 16'h0002);
    repeat (100) @(negedge clock);
    pulse_bad();
    repeat (5) begin
      tmb_enable = 1'b1;
      @(negedge clock);
      tmb_enable = 1'b0;
      @(negedge clock);
    end
    repeat (20000) @(negedge clock);
    rd(16'h9404, 16'h0005);
    rd(16'h9408, 16'h0001);
    rd(16'h940C, 16'h0003);
    access(1'b1, 16'h9410, 16'h0000);
    rd(16'h940C, 16'h0000);
    rd(16'h9408, 16'h0001);
    rd(16'h9208, 16'h0002);
    stop_test();
  end
endmodule

// [tb/lpt_far_end.sv]
// Purpose: far-end model: link loopbacks and PRBS-7 sources
// Assumes: one clock, streams on the system clock
// Notes: bad flips exactly one received bit per high cycle
`include "lpt_map.svh"

module lpt_far_end
  import lpt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic bad,
  input wire lpt_bit_s ro_tx,
  input wire lpt_bit_s pc_tx,
  output lpt_bit_s ro_rx,
  output lpt_bit_s pc_rx,
  output lpt_bit_s [`LPT_FIBERS-1:0] fe_rx,
  output lpt_bit_s tmb_rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] lfsr_r;
  logic gen_r;
  // Source b[n] = b[n-7] ^ b[n-6]; idle loop lines toggle, never hold
  always_ff @(posedge clock) begin
    if (!resetn) begin
      lfsr_r <= 7'h5A;
      gen_r <= 1'b0;
      ro_rx <= '0;
      pc_rx <= '0;
    end else begin
      lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]};
      gen_r <= lfsr_r[6] ^ lfsr_r[5];
      ro_rx.valid <= ro_tx.valid;
      ro_rx.data <= ro_tx.valid ? ro_tx.data ^ bad : ~ro_rx.data;
      pc_rx.valid <= pc_tx.valid;
      pc_rx.data <= pc_tx.valid ? pc_tx.data ^ bad : ~pc_rx.data;
    end
  end
  // Only fiber 0 carries a pattern; the others are dark
  always_comb begin
    for (int i = 0; i < `LPT_FIBERS; i++) fe_rx[i] = '{1'b0, ~gen_r};
    fe_rx[0] = '{1'b1, gen_r ^ bad};
  end
  assign tmb_rx = '{1'b1, gen_r ^ bad};
endmodule

// [tb/lpt_unit_props.sv]
// Purpose: port checks of the link test unit
// Assumes: single clock, synchronous active-low reset
// Notes: attached by bind below
module lpt_unit_props
  import lpt_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire lpt_cmd_s cmd,
  input wire logic cmd_ack,
  input wire logic [15:0] cmd_rdata,
  input wire lpt_bit_s ro_tx,
  input wire lpt_bit_s pc_tx
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_ack_after_cmd: assert property (cmd.strobe |=> cmd_ack)
    else $error("answer missing after command");
  a_ack_has_cause: assert property (cmd_ack |-> $past(cmd.strobe))
    else $error("answer without command");
  a_rdata_quiet: assert property (!cmd_ack |-> cmd_rdata == 16'h0000)
    else $error("read data not zero outside answer");
  a_start_reads_zero: assert property (cmd.strobe && !cmd.write
    && cmd.addr == 16'h9000 |=> cmd_rdata == 16'h0000)
    else $error("write-only start read not zero");
  a_ro_tx_starts: assert property (cmd.strobe && cmd.write
    && cmd.addr == 16'h9000 && cmd.wdata != 16'h0000 |-> ##2 ro_tx.valid)
    else $error("readout transmit did not start");
  a_pc_tx_starts: assert property (cmd.strobe && cmd.write
    && cmd.addr == 16'h9100 && cmd.wdata != 16'h0000 |-> ##2 pc_tx.valid)
    else $error("pc transmit did not start");
  a_ro_tx_prbs: assert property (ro_tx.valid && $past(ro_tx.valid, 7)
    |-> ro_tx.data == ($past(ro_tx.data, 7) ^ $past(ro_tx.data, 6)))
    else $error("readout transmit pattern wrong");
  a_pc_tx_prbs: assert property (pc_tx.valid && $past(pc_tx.valid, 7)
    |-> pc_tx.data == ($past(pc_tx.data, 7) ^ $past(pc_tx.data, 6)))
    else $error("pc transmit pattern wrong");
  a_ro_tx_length: assert property (cmd.strobe && cmd.write
    && cmd.addr == 16'h9000 && cmd.wdata == 16'h0001
    |-> ##128 ro_tx.valid ##1 !ro_tx.valid)
    else $error("readout transmit length wrong");
  a_pc_tx_length: assert property (cmd.strobe && cmd.write
    && cmd.addr == 16'h9100 && cmd.wdata == 16'h0001
    |-> ##128 pc_tx.valid ##1 !pc_tx.valid)
    else $error("pc transmit length wrong");
endmodule

bind lpt_unit lpt_unit_props u_props (.clock(clock), .resetn(resetn),
  .cmd(cmd), .cmd_ack(cmd_ack), .cmd_rdata(cmd_rdata), .ro_tx(ro_tx),
  .pc_tx(pc_tx));
